/* File: core/dsdg_pkg.sv */
// constants and types for the ddr strobe delay and gearing block
package dsdg_pkg;
  localparam int DELAY_W   = 4;
  localparam int LVL_W     = 8;
  localparam int PTR_W     = 3;
  localparam int GEAR_MAX  = 7;
  localparam int ADDR_W    = 12;
  localparam int STAT_W    = 4;

  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MASK   = 12'h008;
  localparam logic [11:0] ADDR_DELAY  = 12'h00C;

  localparam int CTRL_RATIO_LSB = 0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  localparam int ST_RDMAX = 0;
  localparam int ST_WRMAX = 1;
  localparam int ST_VALID = 2;
  localparam int ST_BURST = 3;

  localparam int DLY_RD_LSB  = 0;
  localparam int DLY_WR_LSB  = 8;
  localparam int DLY_WPT_LSB = 16;
  localparam int DLY_RPT_LSB = 20;

  localparam logic [2:0] GEAR_W_1X  = 3'h2;
  localparam logic [2:0] GEAR_W_2X  = 3'h4;
  localparam logic [2:0] GEAR_W_7TO1 = 3'h7;

  typedef enum logic [1:0] {GEAR_1X, GEAR_2X, GEAR_7TO1} dsdg_ratio_type;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} dsdg_rdstate_type;
endpackage : dsdg_pkg

/* File: core/dsdg_top.sv */
// strobe delay, write clocks, fifo pointers, gearing and apb registers
// Overview of operation
// - read strobe passes a slave delay set by the master loop code before capture
// - second slave delay derives the write data clock; the write strobe clock takes the leveling line
// - outputs shifted read strobe, write data clock and write strobe clock
// - third delay line for write leveling, set by an 8-bit core input
// - read and write delays shift independently via load_n, step and direction
// - read margin flag asserts when the adjusted read delay reaches maximum
// - write margin flag asserts when the adjusted write delay reaches maximum
// - 3-bit fifo read and write pointers go to the group's capture fifos
// - controller pauses during code update or leveling; write outputs then hold
// - data-valid marks start of read data; burst detect indicator output
// - input gearing delivers pin data as 2, 4 or 7 bit words
// - core word-align request shifts the alignment of delivered words
// - side banks gear 1x, 2x, 7:1; top banks only 1x
// - output path captures core signals in flip-flops before the buffers
// - gearing reset input resets the output logic
`timescale 1ns/1ps
module dsdg_top #(
  parameter int  DELAY_W  = dsdg_pkg::DELAY_W,
  parameter int  LVL_W    = dsdg_pkg::LVL_W,
  parameter bit  TOP_BANK = 1'b0
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_b,
  input  wire logic [dsdg_pkg::ADDR_W-1:0]     paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  output logic                                 irq,
  input  wire logic                            memStrobe,
  input  wire logic                            fastEdgeClock,
  input  wire logic [DELAY_W-1:0]              strobeDelayCode,
  input  wire logic                            readMarginLoad_n,
  input  wire logic                            readMarginStep,
  input  wire logic                            readMarginDir,
  input  wire logic                            writeMarginLoad_n,
  input  wire logic                            writeMarginStep,
  input  wire logic                            writeMarginDir,
  input  wire logic [LVL_W-1:0]                writeLevelDelay,
  input  wire logic                            pause,
  input  wire logic [1:0]                      readRequest,
  input  wire logic [1:0]                      readPulseSelect,
  output logic                                 readStrobeShifted,
  output logic                                 writeDataClock,
  output logic                                 writeStrobeClock,
  output logic      [dsdg_pkg::PTR_W-1:0]      fifoReadPointer,
  output logic      [dsdg_pkg::PTR_W-1:0]      fifoWritePointer,
  output logic                                 readDataValid,
  output logic                                 burstDetect,
  output logic                                 readMarginMaxFlag,
  output logic                                 writeMarginMaxFlag,
  input  wire logic                            pinData,
  input  wire logic                            wordAlignRequest,
  output logic      [dsdg_pkg::GEAR_MAX-1:0]   gearWord,
  input  wire logic [dsdg_pkg::GEAR_MAX-1:0]   coreWord,
  input  wire logic                            gearReset,
  output logic                                 pinOut
);
  localparam int TAPS = 2 ** DELAY_W;
  localparam int LTAPS = 2 ** LVL_W;
  localparam logic [DELAY_W-1:0] DMAX = '1;

  // bit count per word for a ratio; illegal codes fall back to 1x
  function automatic logic [2:0] gearWidth(input logic [1:0] code);
    logic [2:0] w;
    w = dsdg_pkg::GEAR_W_1X;
    if (!TOP_BANK && code == 2'(dsdg_pkg::GEAR_2X))
      w = dsdg_pkg::GEAR_W_2X;
    if (!TOP_BANK && code == 2'(dsdg_pkg::GEAR_7TO1))
      w = dsdg_pkg::GEAR_W_7TO1;
    return w;
  endfunction : gearWidth

  // margin offset update: load clears, step edge moves with saturation
  function automatic logic [DELAY_W-1:0] nextOffset(input logic [DELAY_W-1:0] off,
      input logic loadN, input logic stepEdge, input logic dir);
    logic [DELAY_W-1:0] n;
    n = off;
    if (!loadN)
      n = '0;
    else if (stepEdge && dir && off != DMAX)
      n = off + DELAY_W'(1);
    else if (stepEdge && !dir && off != '0)
      n = off - DELAY_W'(1);
    return n;
  endfunction : nextOffset

  function automatic logic [DELAY_W-1:0] satAdd(input logic [DELAY_W-1:0] a,
      input logic [DELAY_W-1:0] b);
    logic [DELAY_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[DELAY_W] ? DMAX : s[DELAY_W-1:0];
  endfunction : satAdd

  // pin synchronisers: strobe, edge clock, data
  logic [2:0] syncStrobe;
  logic [2:0] syncEdge;
  logic [2:0] syncData;
  logic       strobeStable;
  logic       edgeStable;
  logic       dataStable;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      syncStrobe   <= 3'h0;
      syncEdge     <= 3'h0;
      syncData     <= 3'h0;
      strobeStable <= 1'b0;
      edgeStable   <= 1'b0;
      dataStable   <= 1'b0;
    end else begin
      syncStrobe <= {syncStrobe[1:0], memStrobe};
      syncEdge   <= {syncEdge[1:0], fastEdgeClock};
      syncData   <= {syncData[1:0], pinData};
      if (syncStrobe[2] == syncStrobe[1])
        strobeStable <= syncStrobe[2];
      if (syncEdge[2] == syncEdge[1])
        edgeStable <= syncEdge[2];
      if (syncData[2] == syncData[1])
        dataStable <= syncData[2];
    end
  end

  // margin offsets and effective delays
  logic [DELAY_W-1:0] readOffset;
  logic [DELAY_W-1:0] writeOffset;
  logic               readStepPrev;
  logic               writeStepPrev;
  logic [DELAY_W-1:0] readDelay;
  logic [DELAY_W-1:0] writeDelay;

  assign readDelay  = satAdd(strobeDelayCode, readOffset);
  assign writeDelay = satAdd(strobeDelayCode, writeOffset);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      readOffset    <= '0;
      writeOffset   <= '0;
      readStepPrev  <= 1'b0;
      writeStepPrev <= 1'b0;
    end else begin
      readStepPrev  <= readMarginStep;
      writeStepPrev <= writeMarginStep;
      readOffset  <= nextOffset(readOffset, readMarginLoad_n,
                                readMarginStep && !readStepPrev, readMarginDir);
      writeOffset <= nextOffset(writeOffset, writeMarginLoad_n,
                                writeMarginStep && !writeStepPrev, writeMarginDir);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      readMarginMaxFlag  <= 1'b0;
      writeMarginMaxFlag <= 1'b0;
    end else begin
      readMarginMaxFlag  <= (readDelay == DMAX);
      writeMarginMaxFlag <= (writeDelay == DMAX);
    end
  end

  // slave delay lines as tapped shift chains
  logic [TAPS-1:0]  readLine;
  logic [TAPS-1:0]  writeLine;
  logic [LTAPS-1:0] levelLine;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      readLine  <= '0;
      writeLine <= '0;
      levelLine <= '0;
    end else begin
      readLine  <= {readLine[TAPS-2:0], strobeStable};
      writeLine <= {writeLine[TAPS-2:0], edgeStable};
      levelLine <= {levelLine[LTAPS-2:0], edgeStable};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      readStrobeShifted <= 1'b0;
      writeDataClock    <= 1'b0;
      writeStrobeClock  <= 1'b0;
    end else begin
      readStrobeShifted <= readLine[readDelay];
      if (!pause) begin
        writeDataClock   <= writeLine[writeDelay];
        writeStrobeClock <= levelLine[writeLevelDelay];
      end
    end
  end

  // fifo pointers
  logic shiftedPrev;
  logic edgePrev;
  logic shiftedRise;
  logic edgeRise;

  assign shiftedRise = readStrobeShifted && !shiftedPrev;
  assign edgeRise    = edgeStable && !edgePrev;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      shiftedPrev      <= 1'b0;
      edgePrev         <= 1'b0;
      fifoWritePointer <= '0;
      fifoReadPointer  <= '0;
    end else begin
      shiftedPrev <= readStrobeShifted;
      edgePrev    <= edgeStable;
      if (shiftedRise)
        fifoWritePointer <= fifoWritePointer + dsdg_pkg::PTR_W'(1);
      if (edgeRise)
        fifoReadPointer <= fifoReadPointer + dsdg_pkg::PTR_W'(1);
    end
  end

  // read window: wait for selected pulse, then count the burst
  dsdg_pkg::dsdg_rdstate_type rdState;
  logic [2:0] edgeCount;
  logic [2:0] burstLen;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdState       <= dsdg_pkg::RD_IDLE;
      edgeCount     <= 3'h0;
      burstLen      <= 3'h0;
      readDataValid <= 1'b0;
      burstDetect   <= 1'b0;
    end else begin
      readDataValid <= 1'b0;
      unique case (rdState)
        dsdg_pkg::RD_IDLE: begin
          if (readRequest != 2'h0) begin
            rdState     <= dsdg_pkg::RD_WAIT;
            edgeCount   <= {1'b0, readPulseSelect};
            burstLen    <= {readRequest, 1'b0};
            burstDetect <= 1'b0;
          end
        end
        dsdg_pkg::RD_WAIT: begin
          if (shiftedRise) begin
            if (edgeCount == 3'h0) begin
              readDataValid <= 1'b1;
              rdState       <= dsdg_pkg::RD_BURST;
              edgeCount     <= burstLen - 3'h1;
            end else begin
              edgeCount <= edgeCount - 3'h1;
            end
          end
        end
        dsdg_pkg::RD_BURST: begin
          if (edgeCount == 3'h0) begin
            burstDetect <= 1'b1;
            rdState     <= dsdg_pkg::RD_IDLE;
          end else if (shiftedRise) begin
            edgeCount <= edgeCount - 3'h1;
          end
        end
      endcase
    end
  end

  // ratio control register
  logic [1:0] ratioCode;
  logic [2:0] wordWidth;

  assign wordWidth = gearWidth(ratioCode);

  // input gearing
  logic [dsdg_pkg::GEAR_MAX-1:0] inShift;
  logic [2:0]                    inCount;
  logic                          alignPrev;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      inShift   <= '0;
      inCount   <= 3'h0;
      alignPrev <= 1'b0;
      gearWord  <= '0;
    end else begin
      alignPrev <= wordAlignRequest;
      if (wordAlignRequest && !alignPrev) begin
        inCount <= 3'h0;
      end else if (edgeRise) begin
        inShift <= {inShift[dsdg_pkg::GEAR_MAX-2:0], dataStable};
        if (inCount == wordWidth - 3'h1) begin
          inCount  <= 3'h0;
          gearWord <= {inShift[dsdg_pkg::GEAR_MAX-2:0], dataStable} &
                      ((7'h01 << wordWidth) - 7'h01);
        end else begin
          inCount <= inCount + 3'h1;
        end
      end
    end
  end

  // output gearing with core capture flops
  logic [dsdg_pkg::GEAR_MAX-1:0] coreCapture;
  logic [dsdg_pkg::GEAR_MAX-1:0] outShift;
  logic [2:0]                    outCount;

  always_ff @(posedge ref_clk) begin
    if (!rst_b || gearReset) begin
      coreCapture <= '0;
      outShift    <= '0;
      outCount    <= 3'h0;
      pinOut      <= 1'b0;
    end else begin
      coreCapture <= coreWord;
      if (edgeRise) begin
        if (outCount == 3'h0) begin
          pinOut   <= coreCapture[0];
          outShift <= coreCapture >> 1;
          outCount <= wordWidth - 3'h1;
        end else begin
          pinOut   <= outShift[0];
          outShift <= outShift >> 1;
          outCount <= outCount - 3'h1;
        end
      end
    end
  end

  // apb slave, one wait state
  logic                      setupDone;
  logic                      doneXfer;
  logic [dsdg_pkg::STAT_W-1:0] status;
  logic [dsdg_pkg::STAT_W-1:0] mask;
  logic [dsdg_pkg::STAT_W-1:0] events;
  logic [dsdg_pkg::STAT_W-1:0] clearBits;
  logic                      rdFlagPrev;
  logic                      wrFlagPrev;
  logic                      burstPrev;

  assign setupDone = psel && penable && !pready;
  assign doneXfer  = psel && penable && pready;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setupDone;
      pslverr <= 1'b0;
      if (setupDone) begin
        prdata <= 32'h0;
        unique case (paddr)
          dsdg_pkg::ADDR_CTRL:   prdata[1:0] <= ratioCode;
          dsdg_pkg::ADDR_STATUS: prdata[dsdg_pkg::STAT_W-1:0] <= status;
          dsdg_pkg::ADDR_MASK:   prdata[dsdg_pkg::STAT_W-1:0] <= mask;
          dsdg_pkg::ADDR_DELAY: begin
            prdata[dsdg_pkg::DLY_RD_LSB +: DELAY_W]  <= readDelay;
            prdata[dsdg_pkg::DLY_WR_LSB +: DELAY_W]  <= writeDelay;
            prdata[dsdg_pkg::DLY_WPT_LSB +: 3]       <= fifoWritePointer;
            prdata[dsdg_pkg::DLY_RPT_LSB +: 3]       <= fifoReadPointer;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ratioCode <= dsdg_pkg::CTRL_RST;
      mask      <= dsdg_pkg::MASK_RST;
    end else if (doneXfer && pwrite) begin
      if (paddr == dsdg_pkg::ADDR_CTRL)
        ratioCode <= pwdata[dsdg_pkg::CTRL_RATIO_LSB +: 2];
      if (paddr == dsdg_pkg::ADDR_MASK)
        mask <= pwdata[dsdg_pkg::STAT_W-1:0];
    end
  end

  // sticky status; a read clears only the bits it reported, new events win
  always_comb begin
    events = '0;
    events[dsdg_pkg::ST_RDMAX] = readMarginMaxFlag && !rdFlagPrev;
    events[dsdg_pkg::ST_WRMAX] = writeMarginMaxFlag && !wrFlagPrev;
    events[dsdg_pkg::ST_VALID] = readDataValid;
    events[dsdg_pkg::ST_BURST] = burstDetect && !burstPrev;
    clearBits = '0;
    if (doneXfer && !pwrite && paddr == dsdg_pkg::ADDR_STATUS)
      clearBits = prdata[dsdg_pkg::STAT_W-1:0];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      status     <= '0;
      rdFlagPrev <= 1'b0;
      wrFlagPrev <= 1'b0;
      burstPrev  <= 1'b0;
      irq        <= 1'b0;
    end else begin
      rdFlagPrev <= readMarginMaxFlag;
      wrFlagPrev <= writeMarginMaxFlag;
      burstPrev  <= burstDetect;
      status     <= (status & ~clearBits) | events;
      irq        <= |(status & mask);
    end
  end
endmodule : dsdg_top

/* File: dv/dsdg_top_sva.sv */
// checker on the strobe delay and gearing top ports
`timescale 1ns/1ps
module dsdg_top_sva #(
  parameter int DELAY_W = dsdg_pkg::DELAY_W
) (
  input wire logic                         ref_clk,
  input wire logic                         rst_b,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         irq,
  input wire logic [DELAY_W-1:0]           strobeDelayCode,
  input wire logic                         readMarginLoad_n,
  input wire logic                         writeMarginLoad_n,
  input wire logic                         readMarginMaxFlag,
  input wire logic                         writeMarginMaxFlag,
  input wire logic                         pause,
  input wire logic                         writeDataClock,
  input wire logic                         writeStrobeClock,
  input wire logic [dsdg_pkg::PTR_W-1:0]   fifoReadPointer,
  input wire logic [dsdg_pkg::PTR_W-1:0]   fifoWritePointer,
  input wire logic                         readDataValid,
  input wire logic                         burstDetect,
  input wire logic                         gearReset,
  input wire logic                         pinOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held past one cycle");
  property p_ready_access;
    pready |-> $past(psel) && $past(penable) && psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside an access phase");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  property p_rd_flag;
    (!readMarginLoad_n && $stable(strobeDelayCode)) [*6] |->
      readMarginMaxFlag == (&strobeDelayCode);
  endproperty
  a_rd_flag: assert property (p_rd_flag)
    else $error("read margin flag does not follow the code");
  property p_wr_flag;
    (!writeMarginLoad_n && $stable(strobeDelayCode)) [*6] |->
      writeMarginMaxFlag == (&strobeDelayCode);
  endproperty
  a_wr_flag: assert property (p_wr_flag)
    else $error("write margin flag does not follow the code");
  property p_pause_hold;
    pause [*3] |-> $stable(writeDataClock) && $stable(writeStrobeClock);
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("write clocks moved during pause");
  property p_wptr_step;
    $changed(fifoWritePointer) |-> fifoWritePointer - $past(fifoWritePointer) == 3'h1;
  endproperty
  a_wptr_step: assert property (p_wptr_step)
    else $error("write pointer skipped");
  property p_rptr_step;
    $changed(fifoReadPointer) |-> fifoReadPointer - $past(fifoReadPointer) == 3'h1;
  endproperty
  a_rptr_step: assert property (p_rptr_step)
    else $error("read pointer skipped");
  property p_valid_pulse;
    readDataValid |=> !readDataValid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("data valid longer than one cycle");
  property p_gear_rst;
    gearReset |=> !pinOut;
  endproperty
  a_gear_rst: assert property (p_gear_rst)
    else $error("pin output not cleared by gearing reset");
  c_access: cover property (psel && penable && pready);
  c_valid: cover property (readDataValid);
  c_burst: cover property ($rose(burstDetect));
  c_irq: cover property ($rose(irq));
endmodule : dsdg_top_sva

bind dsdg_top dsdg_top_sva #(.DELAY_W(DELAY_W)) u_sva (.ref_clk, .rst_b, .psel, .penable,
  .pready, .pslverr, .irq, .strobeDelayCode, .readMarginLoad_n, .writeMarginLoad_n,
  .readMarginMaxFlag, .writeMarginMaxFlag, .pause, .writeDataClock, .writeStrobeClock,
  .fifoReadPointer, .fifoWritePointer, .readDataValid, .burstDetect, .gearReset, .pinOut);

/* File: dv/dsdg_mem_model.sv */
// memory-side model: read strobe bursts and the data line
`timescale 1ns/1ps
module dsdg_mem_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [3:0] edges,
  input  wire logic       dataOn,
  input  wire logic       dataBit,
  output logic            memStrobe,
  output logic            pinData,
  output logic            busy
);
  logic [3:0] left;
  logic [3:0] ph;
  initial begin
    memStrobe = 1'b0;
    pinData = 1'b0;
    busy = 1'b0;
  end
  // strobe stands low between bursts, six cycles per phase
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      left <= edges;
      ph <= 4'h0;
    end else if (busy) begin
      ph <= ph + 4'h1;
      if (ph == 4'h5) memStrobe <= 1'b1;
      if (ph == 4'hB) begin
        memStrobe <= 1'b0;
        ph <= 4'h0;
        left <= left - 4'h1;
        if (left == 4'h1) busy <= 1'b0;
      end
    end
    // undriven data flips every cycle
    pinData <= dataOn ? dataBit : ~pinData;
  end
endmodule : dsdg_mem_model

/* File: dv/dsdg_top_tb.sv */
// self-checking bench for the strobe delay and gearing top
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module dsdg_top_tb;
  logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, irq, rerr, memStrobe, pinData, busy, fastEdgeClock;
  logic [3:0] strobeDelayCode = 4'h0, edges = 4'h0;
  logic readMarginLoad_n = 1'b0, readMarginStep = 1'b0, readMarginDir = 1'b1;
  logic writeMarginLoad_n = 1'b0, writeMarginStep = 1'b0, writeMarginDir = 1'b1;
  logic [7:0] writeLevelDelay = 8'h00;
  logic [1:0] readRequest = 2'h0, readPulseSelect = 2'h0;
  logic pause = 1'b0, wordAlignRequest = 1'b0, gearReset = 1'b0, go = 1'b0;
  logic dataOn = 1'b0, dataBit = 1'b0;
  logic [6:0] gearWord, coreWord = 7'h00;
  logic readStrobeShifted, writeDataClock, writeStrobeClock, readDataValid, burstDetect;
  logic readMarginMaxFlag, writeMarginMaxFlag, pinOut;
  logic [2:0] fifoReadPointer, fifoWritePointer, wp;
  logic [15:0] rnd = 16'h6B76;
  logic [3:0] code;
  logic [2:0] wd;
  int mismatches = 0, compares = 0, vcnt = 0, v0, nr, nw;
  dsdg_top uut (.ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .irq, .memStrobe, .fastEdgeClock, .strobeDelayCode,
    .readMarginLoad_n, .readMarginStep, .readMarginDir, .writeMarginLoad_n,
    .writeMarginStep, .writeMarginDir, .writeLevelDelay, .pause, .readRequest,
    .readPulseSelect, .readStrobeShifted, .writeDataClock, .writeStrobeClock,
    .fifoReadPointer, .fifoWritePointer, .readDataValid, .burstDetect, .readMarginMaxFlag,
    .writeMarginMaxFlag, .pinData, .wordAlignRequest, .gearWord, .coreWord, .gearReset,
    .pinOut);
  dsdg_mem_model u_mem (.ref_clk, .go, .edges, .dataOn, .dataBit, .memStrobe, .pinData,
    .busy);
  always #50 ref_clk = ~ref_clk;
  initial begin
    fastEdgeClock = 1'b0;
    #3037;
    forever #400 fastEdgeClock = ~fastEdgeClock;
  end
  always @(negedge ref_clk) if (readDataValid === 1'b1) vcnt++;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [3:0] sat(input logic [3:0] c, input int k);
    return (int'(c) + k > 15) ? 4'hF : 4'(int'(c) + k);
  endfunction : sat
  task automatic settle(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic margin(input logic [3:0] c, input int r, input int w);
    @(posedge ref_clk);
    strobeDelayCode <= c;
    readMarginLoad_n <= 1'b0;
    writeMarginLoad_n <= 1'b0;
    repeat (7) @(posedge ref_clk);
    readMarginLoad_n <= 1'b1;
    writeMarginLoad_n <= 1'b1;
    readMarginDir <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      readMarginStep <= (i < r || i == 15);
      writeMarginStep <= (i < w);
      readMarginDir <= (i < 15);
      @(posedge ref_clk);
      readMarginStep <= 1'b0;
      writeMarginStep <= 1'b0;
    end
    settle(4);
    `CHK("read flag", sat(c, r > 0 ? r - 1 : 0) == 4'hF, readMarginMaxFlag)
    `CHK("write flag", sat(c, w) == 4'hF, writeMarginMaxFlag)
    apb(1'b0, dsdg_pkg::ADDR_DELAY, 32'h0);
    `CHK("read delay", sat(c, r > 0 ? r - 1 : 0), rdat[3:0])
    `CHK("write delay", sat(c, w), rdat[11:8])
  endtask : margin
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #3000000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `CHK("reset read", 32'h0, rdat)
    end
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    `CHK("unmapped write err", 1'b1, rerr)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped read", 33'h100000000, {rerr, rdat})
    for (int t = 0; t < 6; t++) begin
      rnd = lfsr(rnd);
      code = (t == 0) ? 4'hF : (t == 1) ? 4'h0 : rnd[3:0];
      nr = (t == 0) ? 0 : (t == 1) ? 15 : int'(rnd[7:4]);
      nw = (t == 1) ? 1 : int'(rnd[11:8]);
      margin(code, nr, nw);
    end
    margin(4'h0, 0, 0);
    apb(1'b0, dsdg_pkg::ADDR_STATUS, 32'h0);
    margin(4'hF, 0, 0);
    settle(2);
    `CHK("masked irq", 1'b0, irq)
    apb(1'b1, dsdg_pkg::ADDR_MASK, 32'h3);
    settle(2);
    `CHK("unmasked irq", 1'b1, irq)
    apb(1'b0, dsdg_pkg::ADDR_STATUS, 32'h0);
    `CHK("status flags", 2'h3, rdat[1:0])
    settle(3);
    `CHK("cleared irq", 1'b0, irq)
    margin(4'h0, 0, 0);
    for (int r = 1; r < 4; r++) begin
      settle(1);
      wp = fifoWritePointer;
      v0 = vcnt;
      @(posedge ref_clk);
      readRequest <= 2'(r);
      readPulseSelect <= 2'(r - 1);
      @(posedge ref_clk);
      readRequest <= 2'h0;
      edges <= 4'(3 * r - 1);
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      do @(negedge ref_clk);
      while (busy === 1'b1);
      settle(24);
      `CHK("valid pulses", 1, vcnt - v0)
      `CHK("burst detect", 1'b1, burstDetect)
      `CHK("write pointer", 3'(wp + 3'(3 * r - 1)), fifoWritePointer)
      apb(1'b0, dsdg_pkg::ADDR_STATUS, 32'h0);
      `CHK("status read", 2'h3, rdat[3:2])
    end
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, dsdg_pkg::ADDR_CTRL, 32'(r));
      rnd = lfsr(rnd);
      wd = (r == 1) ? dsdg_pkg::GEAR_W_2X : (r == 2) ? dsdg_pkg::GEAR_W_7TO1 : dsdg_pkg::GEAR_W_1X;
      coreWord <= rnd[0] ? 7'h7F : 7'h00;
      writeLevelDelay <= rnd[15:8];
      gearReset <= 1'b1;
      pause <= (r < 2);
      dataOn <= 1'b1;
      dataBit <= 1'b1;
      wordAlignRequest <= 1'b1;
      @(posedge ref_clk);
      wordAlignRequest <= 1'b0;
      gearReset <= 1'b0;
      settle(150);
      `CHK("gear word", 7'((8'h1 << wd) - 8'h1), gearWord)
      `CHK("pin out", rnd[0], pinOut)
    end
    settle(1);
    wp = fifoReadPointer;
    nr = 0;
    nw = 0;
    for (int i = 0; i < 80; i++) begin
      wd = {writeDataClock, writeStrobeClock, 1'b0};
      settle(0);
      nr += int'(writeDataClock && !wd[2]);
      nw += int'(writeStrobeClock && !wd[1]);
    end
    `CHK("read pointer", 3'(wp + 3'h2), fifoReadPointer)
    `CHK("data clock rises", 10, nr)
    `CHK("strobe clock rises", 10, nw)
    final_report();
  end
endmodule : dsdg_top_tb
